/* test/acoc_chk.sv */
// assertions on the calibration and fallback block ports
`timescale 1ns/10ps
module acoc_chk
(
   input wire i_clock,
   input wire i_rst,
   input wire i_reg_rd,
   input wire [7:0] i_reg_addr,
   input wire i_cal_start,
   input wire i_open_loop_mode,
   input wire i_drive_start,
   input wire [7:0] o_reg_rdata,
   input wire o_cal_busy,
   input wire o_cal_measuring,
   input wire o_cal_done,
   input wire o_auto_overdrive,
   input wire [1:0] o_overdrive_time_clamp,
   input wire o_open_loop,
   input wire o_fallback_active,
   input wire o_sine_wave
);
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   property p_cal_od;
      o_cal_busy |-> o_auto_overdrive && o_overdrive_time_clamp == 2'h0;
   endproperty
   a_cal_od: assert property (p_cal_od) else $error("clamp in cal");
   property p_rsv;
      $past(i_reg_rd) && $past(i_reg_addr) == 8'h2A |-> o_reg_rdata[7:2] == 0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("reserved set");
   property p_done;
      o_cal_done |=> !o_cal_done && !o_cal_busy;
   endproperty
   a_done: assert property (p_done) else $error("done too long");
   property p_meas;
      o_cal_measuring |-> o_cal_busy;
   endproperty
   a_meas: assert property (p_meas) else $error("measure idle");
   property p_start;
      $rose(i_cal_start) && !o_cal_busy && !o_cal_done |-> ##[1:3] o_cal_busy;
   endproperty
   a_start: assert property (p_start) else $error("no start");
   property p_fb;
      o_fallback_active |-> o_open_loop && !o_sine_wave;
   endproperty
   a_fb: assert property (p_fb) else $error("fallback shape");
   property p_olm;
      $past(i_open_loop_mode) && $past(i_open_loop_mode, 2) |-> o_open_loop;
   endproperty
   a_olm: assert property (p_olm) else $error("open loop lost");
   property p_dstart;
      i_drive_start |-> ##[1:3] !o_fallback_active;
   endproperty
   a_dstart: assert property (p_dstart) else $error("fallback kept");
   c_done: cover property (o_cal_done);
   c_fb: cover property ($rose(o_fallback_active));
   c_sine: cover property (o_sine_wave);
endmodule // acoc_chk

bind acoc_top acoc_chk chk_u (.i_clock(i_clock), .i_rst(i_rst),
   .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_cal_start(i_cal_start),
   .i_open_loop_mode(i_open_loop_mode), .i_drive_start(i_drive_start),
   .o_reg_rdata(o_reg_rdata), .o_cal_busy(o_cal_busy),
   .o_cal_measuring(o_cal_measuring), .o_cal_done(o_cal_done),
   .o_auto_overdrive(o_auto_overdrive), .o_open_loop(o_open_loop),
   .o_overdrive_time_clamp(o_overdrive_time_clamp),
   .o_fallback_active(o_fallback_active), .o_sine_wave(o_sine_wave));

/* test/acoc_lra_model.sv */
// actuator model: one zero crossing report every 32 driven cycles
`timescale 1ns/10ps
module acoc_lra_model
(
   input wire i_clock,
   input wire i_active,
   input wire i_stuck,
   output reg o_zc_ok,
   output reg o_zc_fail
);
   reg [4:0] ph_r = 5'h00;
   initial o_zc_ok = 1'b0;
   initial o_zc_fail = 1'b0;
   // a stuck actuator gives no back signal, so each crossing is missed
   always @(posedge i_clock)
   begin
      ph_r <= i_active ? ph_r + 5'h01 : 5'h00;
      o_zc_ok <= i_active && ph_r == 5'h1F && !i_stuck;
      o_zc_fail <= i_active && ph_r == 5'h1F && i_stuck;
   end
endmodule // acoc_lra_model

/* test/actuator_autocal_openloop_cfg_test.sv */
// bench for calibration length, fallback and open-loop settings
`timescale 1ns/10ps
module actuator_autocal_openloop_cfg_test;
   reg clk = 0, rst = 1, wr = 0, rd = 0, cs = 0, xt = 0, en = 0, sw = 0;
   reg olm = 0, ds = 0, act = 0, stuck = 0;
   reg [7:0] addr = 0, wd = 0, plo = 0;
   reg [1:0] clamp = 2'h2;
   wire [7:0] rdat;
   wire [1:0] oclamp;
   wire busy, meas, done, aod, ol, fb, sine, ph, tick, zok, zf;
   integer n_mismatch = 0, tests_run = 0, i, n, hc;
   acoc_top #(.P_MS_CYCLES(18'd10), .P_OL_UNIT_CYCLES(13'd4)) dut_u (
      .i_clock(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
      .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdat),
      .i_open_loop_period_low(plo), .i_cal_start(cs), .i_ext_trigger(xt),
      .i_enable(en), .i_sw_trigger(sw), .i_overdrive_time_clamp(clamp),
      .i_open_loop_mode(olm), .i_drive_start(ds), .i_drive_active(act),
      .i_zero_crossing_ok(zok), .i_zero_crossing_fail(zf),
      .o_cal_busy(busy), .o_cal_measuring(meas), .o_cal_done(done),
      .o_auto_overdrive(aod), .o_overdrive_time_clamp(oclamp),
      .o_open_loop(ol), .o_fallback_active(fb), .o_sine_wave(sine),
      .o_drive_phase(ph), .o_period_tick(tick));
   acoc_lra_model lra_u (.i_clock(clk), .i_active(act), .i_stuck(stuck),
      .o_zc_ok(zok), .o_zc_fail(zf));
   initial forever #2 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////
   task close_out;
   begin
      $display("checks %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   end
   endtask
   task chk(input [31:0] seen, input [31:0] exp, input [63:0] nm);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task cyc(input integer k);
      repeat (k) @(negedge clk);
   endtask
   task wreg(input [7:0] a, input [7:0] d);
   begin
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
   end
   endtask
   task rreg(input [7:0] a, input [7:0] e);
   begin
      @(negedge clk);
      addr = a;
      rd = 1;
      @(negedge clk);
      rd = 0;
      @(negedge clk);
      chk(rdat, e, "rdata");
   end
   endtask
   task pds;
   begin
      @(negedge clk);
      ds = 1;
      @(negedge clk);
      ds = 0;
   end
   endtask
   // waits for k crossing reports of either kind
   task wz(input integer k);
      repeat (k)
      begin
         @(negedge clk);
         while (zok !== 1'b1 && zf !== 1'b1) @(negedge clk);
      end
   endtask
   // e counts falling edges from the start of the wait loop to done
   task cal(input [1:0] s, input [1:0] src, input integer e);
   begin
      wreg(8'h2A, {6'h00, s});
      @(negedge clk);
      cs = 1;
      @(negedge clk);
      cs = 0;
      cyc(5);
      chk({aod, oclamp}, 3'h4, "od_cal");
      if (s == 2'h3)
      begin
         cyc(10000);
         chk(busy, 1, "cal_hold");
         sw = (src == 0);
         xt = (src == 1);
         en = (src == 2);
         @(negedge clk);
         sw = 0;
      end
      n = 0;
      while (done !== 1'b1 && n < 20000)
      begin
         @(negedge clk);
         n = n + 1;
      end
      chk(n, e, "cal_len");
      chk({busy, meas}, 2'h3, "cal_meas");
      xt = 0;
      en = 0;
   end
   endtask
   // e is the period in cycles, h the cycles with the phase high
   task per(input integer e, input integer h);
   begin
      repeat (2)
      begin
         n = 0;
         hc = 0;
         @(negedge clk);
         while (tick !== 1'b1 && n < 3000)
         begin
            @(negedge clk);
            n = n + 1;
            hc = hc + (ph === 1'b1);
         end
      end
      chk(n + 1, e, "period");
      chk(hc, h, "phase");
   end
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      #(4 * 90000);
      n_mismatch = n_mismatch + 1;
      close_out;
   end
   initial
   begin
      cyc(5);
      rst = 0;
      rreg(8'h2A, 8'h02);
      rreg(8'h2C, 8'h00);
      rreg(8'h2E, 8'h00);
      wreg(8'h2A, 8'hFF);
      rreg(8'h2A, 8'h03);
      wreg(8'h2C, 8'hFF);
      rreg(8'h2C, 8'hE1);
      wreg(8'h2E, 8'hFF);
      rreg(8'h2E, 8'h03);
      wreg(8'h55, 8'h12);
      rreg(8'h55, 8'h00);
      // run ms times 10 cycles, plus 4 ms of measuring, less 5 waited
      cal(0, 0, 250 * 10 + 40 - 5);
      cal(1, 0, 500 * 10 + 40 - 5);
      cal(2, 0, 1000 * 10 + 40 - 5);
      // pin cancels pay two more cycles of synchroniser latency
      for (i = 0; i < 3; i = i + 1)
         cal(3, i[1:0], (i == 0) ? 40 : 42);
      cyc(2);
      chk({aod, oclamp}, 3'h2, "od_idle");
      clamp = 2'h0;
      cyc(2);
      chk({aod, oclamp}, 3'h4, "od_auto");
      act = 1;
      for (i = 0; i < 4; i = i + 1)
      begin
         wreg(8'h2C, {1'b1, i[1:0], 5'h01});
         pds;
         stuck = 1;
         wz(2 + i);
         cyc(3);
         chk(fb, 0, "fb_early");
         wz(1);
         cyc(3);
         chk({fb, ol, sine}, 3'h6, "fb_on");
         stuck = 0;
      end
      wreg(8'h2C, 8'h81);
      pds;
      stuck = 1;
      wz(2);
      stuck = 0;
      wz(1);
      stuck = 1;
      wz(2);
      cyc(3);
      chk(fb, 0, "fb_clear");
      wreg(8'h2C, 8'h01);
      pds;
      wz(8);
      cyc(3);
      chk(fb, 0, "fb_off");
      stuck = 0;
      olm = 1;
      cyc(3);
      chk({ol, sine}, 2'h3, "sine");
      wreg(8'h2C, 8'h00);
      cyc(3);
      chk(sine, 0, "square");
      plo = 8'h0A;
      wreg(8'h2E, 8'h00);
      per(40, 20);
      wreg(8'h2E, 8'h01);
      per(1064, 532);
      close_out;
   end
endmodule // actuator_autocal_openloop_cfg_test

/* verilog/acoc_defines.vh */
// constants for the actuator calibration and open-loop configuration block
// How it works
// - calibration length 250/500/1000 ms, selector resets 2
// - selector 3: calibrate until any cancelling trigger
// - after cancel trigger, measure before finishing
// - fallback bit 7 enables auto open loop
// - bits 6-5 give 3 to 6 failed attempts
// - fallback open loop always drives square wave
// - bit 0 picks square or sine in open loop
// - open-loop period is value times 24.615 us
// - calibration forces automatic overdrive, ignores clamp
`ifndef ACOC_DEFINES_VH
`define ACOC_DEFINES_VH

`define ACOC_ADDR_CAL_DUR 8'h2A
`define ACOC_ADDR_FALLBACK 8'h2C
`define ACOC_ADDR_PERIOD_HI 8'h2E

`define ACOC_CAL_DUR_RST 2'h2
`define ACOC_FB_EN_RST 1'h0
`define ACOC_FB_CNT_RST 2'h0
`define ACOC_WAVE_RST 1'h0
`define ACOC_PERIOD_HI_RST 2'h0

`define ACOC_FB_EN_BIT 7
`define ACOC_FB_CNT_HI 6
`define ACOC_FB_CNT_LO 5
`define ACOC_WAVE_BIT 0

`define ACOC_DUR_TRIGGERED 2'h3
`define ACOC_DUR0_MS 10'd250
`define ACOC_DUR1_MS 10'd500
`define ACOC_DUR2_MS 10'd1000
`define ACOC_MEAS_MS 10'd4
`define ACOC_FB_BASE_ATTEMPTS 3'h3

// counts of the 4 ns clock; the open-loop unit is rounded down
`define ACOC_MS_CYCLES 18'h3D090
`define ACOC_OL_UNIT_CYCLES 13'h1809

`endif

/* verilog/acoc_period_gen.v */
// open-loop drive period generator in 24.615 us units
`timescale 1ns/10ps
`include "acoc_defines.vh"

module acoc_period_gen
#(
   parameter [12:0] P_UNIT_CYCLES = `ACOC_OL_UNIT_CYCLES
)
(
   input wire i_clock,
   input wire i_rst,
   input wire i_run,
   input wire [9:0] i_period,
   output reg o_phase,
   output reg o_period_tick
);

reg [12:0] unit_cnt_r;
reg [9:0] step_cnt_r;
wire unit_tick;

assign unit_tick = (unit_cnt_r == P_UNIT_CYCLES - 13'h0001);

always @(posedge i_clock or posedge i_rst)
begin
   if (i_rst)
   begin
      unit_cnt_r <= 13'h0000;
      step_cnt_r <= 10'h000;
      o_phase <= 1'b0;
      o_period_tick <= 1'b0;
   end
   else
   begin
      o_period_tick <= 1'b0;
      if (!i_run || i_period == 10'h000)
      begin
         unit_cnt_r <= 13'h0000;
         step_cnt_r <= 10'h000;
         o_phase <= 1'b0;
      end
      else if (unit_tick)
      begin
         unit_cnt_r <= 13'h0000;
         // period = value times one unit
         if (step_cnt_r >= i_period - 10'h001)
         begin
            step_cnt_r <= 10'h000;
            o_phase <= 1'b0;
            o_period_tick <= 1'b1;
         end
         else
         begin
            step_cnt_r <= step_cnt_r + 10'h001;
            if (step_cnt_r + 10'h001 == {1'b0, i_period[9:1]})
               o_phase <= 1'b1;
         end
      end
      else
         unit_cnt_r <= unit_cnt_r + 13'h0001;
   end
end

endmodule // acoc_period_gen

/* verilog/acoc_top.v */
// calibration sequencer, fallback logic and configuration registers
`timescale 1ns/10ps
`include "acoc_defines.vh"

module acoc_top
#(
   parameter [17:0] P_MS_CYCLES = `ACOC_MS_CYCLES,
   parameter [12:0] P_OL_UNIT_CYCLES = `ACOC_OL_UNIT_CYCLES
)
(
   input wire i_clock,
   input wire i_rst,
   input wire [7:0] i_reg_addr,
   input wire [7:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   output reg [7:0] o_reg_rdata,
   input wire [7:0] i_open_loop_period_low,
   input wire i_cal_start,
   input wire i_ext_trigger,
   input wire i_enable,
   input wire i_sw_trigger,
   input wire [1:0] i_overdrive_time_clamp,
   input wire i_open_loop_mode,
   input wire i_drive_start,
   input wire i_drive_active,
   input wire i_zero_crossing_ok,
   input wire i_zero_crossing_fail,
   output reg o_cal_busy,
   output reg o_cal_measuring,
   output reg o_cal_done,
   output reg o_auto_overdrive,
   output reg [1:0] o_overdrive_time_clamp,
   output reg o_open_loop,
   output reg o_fallback_active,
   output reg o_sine_wave,
   output reg o_drive_phase,
   output reg o_period_tick
);

localparam [1:0] ST_IDLE = 2'h0;
localparam [1:0] ST_RUN = 2'h1;
localparam [1:0] ST_MEAS = 2'h2;

////////////////////////////////////////////////////////////////////////////
// decoders

function [9:0] dur_ms;
   input [1:0] sel;
   begin
      case (sel)
         2'h0: dur_ms = `ACOC_DUR0_MS;
         2'h1: dur_ms = `ACOC_DUR1_MS;
         default: dur_ms = `ACOC_DUR2_MS;
      endcase
   end
endfunction

function [2:0] attempts;
   input [1:0] cnt;
   begin
      attempts = `ACOC_FB_BASE_ATTEMPTS + {1'b0, cnt};
   end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers: trigger and enable come from outside the clock domain

wire [1:0] pin_in;
reg [1:0] sync1_r;
reg [1:0] sync2_r;
reg [1:0] sync3_r;
wire [1:0] pin_rise;

assign pin_in = {i_enable, i_ext_trigger};

genvar gi;
generate
   for (gi = 0; gi < 2; gi = gi + 1)
   begin : g_sync
      always @(posedge i_clock or posedge i_rst)
      begin
         if (i_rst)
         begin
            sync1_r[gi] <= 1'b0;
            sync2_r[gi] <= 1'b0;
            sync3_r[gi] <= 1'b0;
         end
         else
         begin
            sync1_r[gi] <= pin_in[gi];
            sync2_r[gi] <= sync1_r[gi];
            sync3_r[gi] <= sync2_r[gi];
         end
      end
      assign pin_rise[gi] = sync2_r[gi] & ~sync3_r[gi];
   end
endgenerate

////////////////////////////////////////////////////////////////////////////
// registers

reg [1:0] cal_dur_r;
reg fb_en_r;
reg [1:0] fb_cnt_r;
reg wave_sel_r;
reg [1:0] period_hi_r;

always @(posedge i_clock or posedge i_rst)
begin
   if (i_rst)
   begin
      cal_dur_r <= `ACOC_CAL_DUR_RST;
      fb_en_r <= `ACOC_FB_EN_RST;
      fb_cnt_r <= `ACOC_FB_CNT_RST;
      wave_sel_r <= `ACOC_WAVE_RST;
      period_hi_r <= `ACOC_PERIOD_HI_RST;
      o_reg_rdata <= 8'h00;
   end
   else
   begin
      if (i_reg_wr)
      begin
         case (i_reg_addr)
            `ACOC_ADDR_CAL_DUR:
               cal_dur_r <= i_reg_wdata[1:0];
            `ACOC_ADDR_FALLBACK:
            begin
               fb_en_r <= i_reg_wdata[`ACOC_FB_EN_BIT];
               fb_cnt_r <= i_reg_wdata[`ACOC_FB_CNT_HI:`ACOC_FB_CNT_LO];
               wave_sel_r <= i_reg_wdata[`ACOC_WAVE_BIT];
            end
            `ACOC_ADDR_PERIOD_HI:
               period_hi_r <= i_reg_wdata[1:0];
            default:
               cal_dur_r <= cal_dur_r;
         endcase
      end
      if (i_reg_rd)
      begin
         case (i_reg_addr)
            `ACOC_ADDR_CAL_DUR: o_reg_rdata <= {6'h00, cal_dur_r};
            `ACOC_ADDR_FALLBACK:
               o_reg_rdata <= {fb_en_r, fb_cnt_r, 4'h0, wave_sel_r};
            `ACOC_ADDR_PERIOD_HI: o_reg_rdata <= {6'h00, period_hi_r};
            default: o_reg_rdata <= 8'h00;
         endcase
      end
   end
end

////////////////////////////////////////////////////////////////////////////
// calibration sequencer

reg [1:0] state_r;
reg [1:0] state_nxt;
reg [17:0] ms_cnt_r;
reg [9:0] ms_left_r;
reg [1:0] mode_r;
wire ms_tick;
wire cancel;

assign ms_tick = (ms_cnt_r == P_MS_CYCLES - 18'h00001);
// any of the three sources ends a trigger-ended run
assign cancel = pin_rise[0] | pin_rise[1] | i_sw_trigger;

always @*
begin
   state_nxt = state_r;
   case (state_r)
      ST_IDLE:
         if (i_cal_start)
            state_nxt = ST_RUN;
      ST_RUN:
         if (mode_r == `ACOC_DUR_TRIGGERED)
         begin
            if (cancel)
               state_nxt = ST_MEAS;
         end
         else if (ms_tick && ms_left_r == 10'h001)
            state_nxt = ST_MEAS;
      ST_MEAS:
         if (ms_tick && ms_left_r == 10'h001)
            state_nxt = ST_IDLE;
      default:
         state_nxt = ST_IDLE;
   endcase
end

always @(posedge i_clock or posedge i_rst)
begin
   if (i_rst)
   begin
      state_r <= ST_IDLE;
      ms_cnt_r <= 18'h00000;
      ms_left_r <= 10'h000;
      mode_r <= 2'h0;
      o_cal_done <= 1'b0;
   end
   else
   begin
      state_r <= state_nxt;
      o_cal_done <= (state_r == ST_MEAS) && (state_nxt == ST_IDLE);
      if (state_r == ST_IDLE || ms_tick || state_nxt != state_r)
         ms_cnt_r <= 18'h00000;
      else
         ms_cnt_r <= ms_cnt_r + 18'h00001;
      if (state_r == ST_IDLE && i_cal_start)
      begin
         // duration is latched so a mid-run write cannot cut it short
         mode_r <= cal_dur_r;
         ms_left_r <= dur_ms(cal_dur_r);
      end
      else if (state_r == ST_RUN && state_nxt == ST_MEAS)
         ms_left_r <= `ACOC_MEAS_MS;
      else if (ms_tick && ms_left_r != 10'h000)
         ms_left_r <= ms_left_r - 10'h001;
   end
end

////////////////////////////////////////////////////////////////////////////
// open-loop fallback

reg [2:0] fail_cnt_r;
reg fallback_r;

always @(posedge i_clock or posedge i_rst)
begin
   if (i_rst)
   begin
      fail_cnt_r <= 3'h0;
      fallback_r <= 1'b0;
   end
   else
   begin
      if (i_zero_crossing_ok || i_drive_start || !fb_en_r)
         fail_cnt_r <= 3'h0;
      else if (i_zero_crossing_fail && fail_cnt_r != 3'h7)
         fail_cnt_r <= fail_cnt_r + 3'h1;
      // stays in open loop until the next drive starts or fallback bit 7 is cleared
      if (i_drive_start || !fb_en_r)
         fallback_r <= 1'b0;
      else if (fail_cnt_r >= attempts(fb_cnt_r) && i_drive_active)
         fallback_r <= 1'b1;
   end
end

////////////////////////////////////////////////////////////////////////////
// drive outputs

wire ol_run;
wire gen_phase;
wire gen_tick;

assign ol_run = i_drive_active & (i_open_loop_mode | fallback_r);

acoc_period_gen #(
   .P_UNIT_CYCLES(P_OL_UNIT_CYCLES)
) u_period_gen (
   .i_clock(i_clock),
   .i_rst(i_rst),
   .i_run(ol_run),
   .i_period({period_hi_r, i_open_loop_period_low}),
   .o_phase(gen_phase),
   .o_period_tick(gen_tick)
);

always @(posedge i_clock or posedge i_rst)
begin
   if (i_rst)
   begin
      o_cal_busy <= 1'b0;
      o_cal_measuring <= 1'b0;
      o_auto_overdrive <= 1'b0;
      o_overdrive_time_clamp <= 2'h0;
      o_open_loop <= 1'b0;
      o_fallback_active <= 1'b0;
      o_sine_wave <= 1'b0;
      o_drive_phase <= 1'b0;
      o_period_tick <= 1'b0;
   end
   else
   begin
      o_cal_busy <= (state_r != ST_IDLE);
      o_cal_measuring <= (state_r == ST_MEAS);
      o_auto_overdrive <= (state_r != ST_IDLE) |
                          (i_overdrive_time_clamp == 2'h0);
      o_overdrive_time_clamp <= (state_r != ST_IDLE) ?
                                2'h0 : i_overdrive_time_clamp;
      o_open_loop <= i_open_loop_mode | fallback_r;
      o_fallback_active <= fallback_r;
      // fallback forces square whatever the select bit says
      o_sine_wave <= (i_open_loop_mode | fallback_r) & ~fallback_r &
                     wave_sel_r;
      o_drive_phase <= gen_phase;
      o_period_tick <= gen_tick;
   end
end

endmodule // acoc_top
